/* logic/mdi_meter_ctrl.sv */
// Command interpreter: power-on state, change latencies, interrupt mask
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////
// Function
// R01: Power-on: DC voltage, 8V, 16.7 ms, autozero on, others immediate/one.
// R02: Power-on encodings: function 00, range 02, aperture 01, others 00; code loads trigger and sample counts 1 and sample period 50000.
// R03: Same latencies apply to any command path reaching this interpreter.
// R04: DC voltage/resistance swap 750 us; from AC voltage 12 ms.
// R05: Into AC voltage: 530 ms with autozero on, 15 ms off.
// R06: DC/resistance aperture set: 123, 106, 36, 24 or 23 ms.
// R07: Any aperture set in AC voltage mode takes 1.0 s.
// R08: Entering AC voltage loads 250 ms trigger delay; later command overrides.
// R09: Range change keeps device busy about 200 us.
// R10: Mask bit 0 enables interrupt on reading available.
// R11: Mask bit 1 enables interrupt while status bit 7 is one.
// R12: Mask bit 2 enables interrupt while status bit 6 is zero.
// R13: Mask bit 3 enables interrupt while status bit 5 is one.
// R14: Mask bit 4 enables interrupt at data buffer half full.
// R15: Host writes opcode 26 then condition weight to enable interrupts.
// R16: Query opcode 34 returns the enabled interrupt mask.
// R17: Interrupt request is driven out to the backplane.
// R18: Error clears status bit 6, stores code; send-error returns it.
// R19: Request only while an enabled condition is true; zero mask disables.
// R20: Busy held while any change latency runs.
module mdi_meter_ctrl #(
    parameter int CNT_W = 28
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // Measurement events
    input wire logic readingAvail,
    input wire logic measComplete,
    input wire logic bufHalfFull,
    // Backplane and state
    output logic irqOut,
    output logic busyOut,
    output logic [7:0] funcOut,
    output logic [7:0] rangeOut,
    output logic [7:0] apertureOut,
    output logic [23:0] trigDelayOut
);
    //////////////////////////////////////////////////////////////////////
    mdi_pkg::mdi_cmd_state_t st_q;
    mdi_pkg::mdi_cmd_state_t st_d;
    logic [7:0] op_q, op_d;
    logic [7:0] par_q, par_d;
    logic [1:0] pcnt_q, pcnt_d;
    logic [7:0] func_q, func_d;
    logic [7:0] range_q, range_d;
    logic [7:0] aper_q, aper_d;
    logic [7:0] azero_q, azero_d;
    logic [23:0] tdel_q, tdel_d;
    logic [7:0] err_q, err_d;
    logic [4:0] mask_q, mask_d;
    logic [7:0] resp_q, resp_d;
    logic [7:0] rd_q, rd_d;
    logic done_q, done_d;
    logic noErr_q, noErr_d;
    logic cmpl_q, cmpl_d;
    logic rdy_q, rdy_d;
    logic load;
    logic [CNT_W-1:0] loadCycles;
    logic busy;
    logic [4:0] cond;
    logic irqReq;
    logic busy_q;
    logic [7:0] offComp_q, trigSrc_q, sampSrc_q, arm_q;
    logic [23:0] trigCnt_q, sampCnt_q;
    logic [15:0] sampPer_q;

    //////////////////////////////////////////////////////////////////////
    // Latency choice for function and aperture changes
    function automatic logic [CNT_W-1:0] fnCycles(
        input logic [7:0] from, input logic [7:0] to, input logic az
    );
        int c;
        c = mdi_pkg::CYC_FN_DC_RES; // R04
        if (to == mdi_pkg::FN_ACV) begin
            c = az ? mdi_pkg::CYC_FN_TO_AC_AZ : mdi_pkg::CYC_FN_TO_AC; // R05
        end else if (from == mdi_pkg::FN_ACV) begin
            c = mdi_pkg::CYC_FN_FROM_AC; // R04
        end
        return CNT_W'(c);
    endfunction

    function automatic logic [CNT_W-1:0] apCycles(
        input logic [7:0] fn, input logic [7:0] ap
    );
        int c;
        case (ap)
            mdi_pkg::AP_320MS, mdi_pkg::AP_20MS: c = mdi_pkg::CYC_AP_123;
            mdi_pkg::AP_267MS, mdi_pkg::AP_16MS7: c = mdi_pkg::CYC_AP_106;
            mdi_pkg::AP_2MS5: c = mdi_pkg::CYC_AP_36;
            mdi_pkg::AP_100US: c = mdi_pkg::CYC_AP_24;
            default: c = mdi_pkg::CYC_AP_23; // R06
        endcase
        if (fn == mdi_pkg::FN_ACV) begin
            c = mdi_pkg::CYC_AP_AC; // R07
        end
        return CNT_W'(c);
    endfunction

    //////////////////////////////////////////////////////////////////////
    // Command interpreter next state
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        par_d = par_q;
        pcnt_d = pcnt_q;
        func_d = func_q;
        range_d = range_q;
        aper_d = aper_q;
        azero_d = azero_q;
        tdel_d = tdel_q;
        err_d = err_q;
        mask_d = mask_q;
        resp_d = resp_q;
        noErr_d = noErr_q;
        load = 1'b0;
        loadCycles = '0;
        case (st_q)
            mdi_pkg::CS_IDLE: begin
                if (regWrite && regAddr == mdi_pkg::OFS_CMD) begin
                    op_d = regWrData;
                    pcnt_d = 2'd0;
                    case (regWrData)
                        mdi_pkg::OP_FUNC, mdi_pkg::OP_RANGE,
                        mdi_pkg::OP_APER, mdi_pkg::OP_AZERO,
                        mdi_pkg::OP_IRQ_EN: st_d = mdi_pkg::CS_PARAM;
                        mdi_pkg::OP_TDELAY: st_d = mdi_pkg::CS_PARAM;
                        mdi_pkg::OP_SEND_ERR: begin
                            resp_d = err_q; // R18
                            err_d = mdi_pkg::ERR_NONE;
                            noErr_d = 1'b1;
                        end
                        mdi_pkg::OP_IRQ_QRY: begin
                            resp_d = {3'b000, mask_q}; // R16
                        end
                        mdi_pkg::OP_STAT_QRY: begin
                            resp_d = func_q;
                        end
                        default: begin
                            err_d = mdi_pkg::ERR_BAD_OP; // R18
                            noErr_d = 1'b0;
                        end
                    endcase
                end
            end
            mdi_pkg::CS_PARAM: begin
                if (regWrite && regAddr == mdi_pkg::OFS_PARAM) begin
                    par_d = regWrData;
                    if (op_q == mdi_pkg::OP_TDELAY) begin
                        // Three bytes, high first; each shifts in as written
                        tdel_d = {tdel_q[15:0], regWrData}; // R08
                        pcnt_d = pcnt_q + 2'd1;
                        if (pcnt_q == 2'd2) begin
                            st_d = mdi_pkg::CS_IDLE;
                        end
                    end else begin
                        st_d = mdi_pkg::CS_EXEC;
                    end
                end
            end
            mdi_pkg::CS_EXEC: begin
                st_d = mdi_pkg::CS_IDLE;
                case (op_q)
                    mdi_pkg::OP_FUNC: begin
                        if (par_q > mdi_pkg::FN_RES) begin
                            err_d = mdi_pkg::ERR_BAD_PARAM;
                            noErr_d = 1'b0;
                        end else if (par_q != func_q) begin
                            func_d = par_q;
                            load = 1'b1; // R03
                            loadCycles = fnCycles(func_q, par_q,
                                azero_q == mdi_pkg::RST_AZERO);
                            if (par_q == mdi_pkg::FN_ACV) begin
                                tdel_d = mdi_pkg::ACV_TDELAY; // R08
                            end
                        end
                    end
                    mdi_pkg::OP_APER: begin
                        if (par_q > mdi_pkg::AP_20MS) begin
                            err_d = mdi_pkg::ERR_BAD_PARAM;
                            noErr_d = 1'b0;
                        end else begin
                            aper_d = par_q;
                            load = 1'b1;
                            loadCycles = apCycles(func_q, par_q);
                        end
                    end
                    mdi_pkg::OP_RANGE: begin
                        range_d = par_q;
                        load = 1'b1;
                        loadCycles = CNT_W'(mdi_pkg::CYC_RANGE); // R09
                    end
                    mdi_pkg::OP_AZERO: azero_d = par_q;
                    mdi_pkg::OP_IRQ_EN: begin
                        if (par_q > 8'h1F) begin
                            err_d = mdi_pkg::ERR_BAD_PARAM;
                            noErr_d = 1'b0;
                        end else begin
                            mask_d = par_q[4:0]; // R15
                        end
                    end
                    default: ;
                endcase
            end
            default: st_d = mdi_pkg::CS_IDLE;
        endcase
        // Read data stands in the cycle after the strobe only
        rd_d = 8'h00;
        if (regRead) begin
            case (regAddr)
                mdi_pkg::OFS_RESP: rd_d = resp_q;
                mdi_pkg::OFS_STATUS:
                    rd_d = {done_q, noErr_q, cmpl_q, 4'h0, busy_q};
                default: rd_d = 8'h00;
            endcase
        end
        // Sticky flags: set wins over clear
        done_d = (done_q && !(regRead && regAddr == mdi_pkg::OFS_STATUS))
            || (busy_q && !busy);
        cmpl_d = (cmpl_q && !(regRead && regAddr == mdi_pkg::OFS_STATUS))
            || measComplete;
        rdy_d = (rdy_q && !(regRead && regAddr == mdi_pkg::OFS_RESP))
            || readingAvail;
    end

    //////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_q <= mdi_pkg::CS_IDLE;
            op_q <= 8'h00;
            par_q <= 8'h00;
            pcnt_q <= 2'd0;
            func_q <= mdi_pkg::RST_FUNC; // R01
            range_q <= mdi_pkg::RST_RANGE; // R02
            aper_q <= mdi_pkg::RST_APER; // R02
            azero_q <= mdi_pkg::RST_AZERO; // R01
            offComp_q <= mdi_pkg::RST_OFFCOMP;
            trigSrc_q <= mdi_pkg::RST_TRIGSRC;
            sampSrc_q <= mdi_pkg::RST_SAMPSRC;
            arm_q <= mdi_pkg::RST_ARM;
            trigCnt_q <= mdi_pkg::RST_TRIG_CNT;
            sampCnt_q <= mdi_pkg::RST_SAMP_CNT;
            sampPer_q <= mdi_pkg::RST_SAMP_PER;
            tdel_q <= mdi_pkg::RST_TDELAY;
            err_q <= mdi_pkg::ERR_NONE;
            mask_q <= 5'h00;
            resp_q <= 8'h00;
            rd_q <= 8'h00;
            done_q <= 1'b0;
            noErr_q <= 1'b1;
            cmpl_q <= 1'b0;
            rdy_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            par_q <= par_d;
            pcnt_q <= pcnt_d;
            func_q <= func_d;
            range_q <= range_d;
            aper_q <= aper_d;
            azero_q <= azero_d;
            tdel_q <= tdel_d;
            err_q <= err_d;
            mask_q <= mask_d;
            resp_q <= resp_d;
            rd_q <= rd_d;
            done_q <= done_d;
            noErr_q <= noErr_d;
            cmpl_q <= cmpl_d;
            rdy_q <= rdy_d;
            busy_q <= busy || load; // R20
        end
    end

    //////////////////////////////////////////////////////////////////////
    mdi_busy_timer #(.CNT_W(CNT_W)) u_busy (
        .core_clk(core_clk),
        .reset(reset),
        .load(load),
        .loadCycles(loadCycles),
        .busy(busy)
    );

    assign cond[mdi_pkg::MB_RDY] = rdy_q; // R10
    assign cond[mdi_pkg::MB_DONE] = done_q; // R11
    assign cond[mdi_pkg::MB_ERR] = !noErr_q; // R12
    assign cond[mdi_pkg::MB_CMPL] = cmpl_q; // R13
    assign cond[mdi_pkg::MB_HALF] = bufHalfFull; // R14

    mdi_irq_gate #(.MASK_W(mdi_pkg::MASK_W)) u_irq (
        .core_clk(core_clk),
        .reset(reset),
        .cond(cond),
        .mask(mask_q),
        .irqReq(irqReq)
    );

    assign irqOut = irqReq; // R17
    assign busyOut = busy_q;
    assign regRdData = rd_q;
    assign funcOut = func_q;
    assign rangeOut = range_q;
    assign apertureOut = aper_q;
    assign trigDelayOut = tdel_q;

    //////////////////////////////////////////////////////////////////////
    a_irq_masked: assert property (@(posedge core_clk) disable iff (reset)
        (mask_q == 5'h00) |=> !irqOut) else $error("irq with zero mask"); // R19
    a_irq_mask_wr: assert property (@(posedge core_clk) disable iff (reset)
        (st_q == mdi_pkg::CS_EXEC && op_q == mdi_pkg::OP_IRQ_EN
         && par_q <= 8'h1F) |=> mask_q == $past(par_q[4:0]))
        else $error("mask not written"); // R15
    a_range_busy: assert property (@(posedge core_clk) disable iff (reset)
        (load && op_q == mdi_pkg::OP_RANGE) |=> busyOut [*8])
        else $error("range busy short"); // R09
    a_acv_delay: assert property (@(posedge core_clk) disable iff (reset)
        (st_q == mdi_pkg::CS_EXEC && op_q == mdi_pkg::OP_FUNC
         && par_q == mdi_pkg::FN_ACV && func_q != mdi_pkg::FN_ACV)
        |=> trigDelayOut == mdi_pkg::ACV_TDELAY)
        else $error("no acv delay"); // R08
    a_err_flag: assert property (@(posedge core_clk) disable iff (reset)
        (err_q != mdi_pkg::ERR_NONE) |-> !noErr_q)
        else $error("error flag mismatch"); // R18
    a_query_mask: assert property (@(posedge core_clk) disable iff (reset)
        (st_q == mdi_pkg::CS_IDLE && regWrite && regAddr == mdi_pkg::OFS_CMD
         && regWrData == mdi_pkg::OP_IRQ_QRY) |=> resp_q == {3'b000, mask_q})
        else $error("bad mask query"); // R16
    a_rdy_irq: assert property (@(posedge core_clk) disable iff (reset)
        (rdy_q && mask_q[mdi_pkg::MB_RDY]) |=> irqOut)
        else $error("ready irq missing"); // R10
    a_half_irq: assert property (@(posedge core_clk) disable iff (reset)
        (bufHalfFull && mask_q[mdi_pkg::MB_HALF]) |=> irqOut)
        else $error("half irq missing"); // R14
endmodule // mdi_meter_ctrl

/* logic/mdi_pkg.sv */
// Package: opcodes, power-on encodings and latency constants
package mdi_pkg;
    // Clock
    localparam int CLK_MHZ = 100;
    // Register port offsets (byte addresses)
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_PARAM = 4'h4;
    localparam logic [3:0] OFS_RESP = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hC;
    // Command opcodes
    localparam logic [7:0] OP_FUNC = 8'h01;
    localparam logic [7:0] OP_RANGE = 8'h02;
    localparam logic [7:0] OP_APER = 8'h03;
    localparam logic [7:0] OP_AZERO = 8'h04;
    localparam logic [7:0] OP_TDELAY = 8'h17;
    localparam logic [7:0] OP_SEND_ERR = 8'h0F;
    localparam logic [7:0] OP_IRQ_EN = 8'h1A;
    localparam logic [7:0] OP_IRQ_QRY = 8'h22;
    localparam logic [7:0] OP_STAT_QRY = 8'h05;
    // Error codes
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_BAD_OP = 8'h01;
    localparam logic [7:0] ERR_BAD_PARAM = 8'h03;
    // Function codes
    localparam logic [7:0] FN_DCV = 8'h00;
    localparam logic [7:0] FN_ACV = 8'h01;
    localparam logic [7:0] FN_RES = 8'h02;
    // Aperture codes
    localparam logic [7:0] AP_320MS = 8'h00;
    localparam logic [7:0] AP_16MS7 = 8'h01;
    localparam logic [7:0] AP_2MS5 = 8'h02;
    localparam logic [7:0] AP_100US = 8'h03;
    localparam logic [7:0] AP_10US = 8'h04;
    localparam logic [7:0] AP_267MS = 8'h05;
    localparam logic [7:0] AP_20MS = 8'h06;
    // Power-on encodings
    localparam logic [7:0] RST_FUNC = 8'h00;
    localparam logic [7:0] RST_RANGE = 8'h02;
    localparam logic [7:0] RST_APER = 8'h01;
    localparam logic [7:0] RST_AZERO = 8'h00;
    localparam logic [7:0] RST_OFFCOMP = 8'h00;
    localparam logic [7:0] RST_TRIGSRC = 8'h00;
    localparam logic [7:0] RST_SAMPSRC = 8'h00;
    localparam logic [7:0] RST_ARM = 8'h00;
    localparam logic [23:0] RST_TRIG_CNT = 24'h000001;
    localparam logic [23:0] RST_SAMP_CNT = 24'h000001;
    localparam logic [23:0] RST_TDELAY = 24'h000000;
    localparam int SAMP_RATE_MS = 50;
    localparam logic [15:0] RST_SAMP_PER = 16'(SAMP_RATE_MS * 1000);
    localparam int ACV_TDELAY_MS = 250;
    localparam logic [23:0] ACV_TDELAY = 24'(ACV_TDELAY_MS * 1000);
    // Status bits
    localparam int ST_DONE = 7;
    localparam int ST_NOERR = 6;
    localparam int ST_COMPLETE = 5;
    // Mask bits
    localparam int MB_RDY = 0;
    localparam int MB_DONE = 1;
    localparam int MB_ERR = 2;
    localparam int MB_CMPL = 3;
    localparam int MB_HALF = 4;
    localparam int MASK_W = 5;
    // Latencies in microseconds; cycles derived
    localparam int T_FN_DC_RES_US = 750;
    localparam int T_FN_FROM_AC_US = 12000;
    localparam int T_FN_TO_AC_AZ_US = 530000;
    localparam int T_FN_TO_AC_US = 15000;
    localparam int T_AP_123_US = 123000;
    localparam int T_AP_106_US = 106000;
    localparam int T_AP_36_US = 36000;
    localparam int T_AP_24_US = 24000;
    localparam int T_AP_23_US = 23000;
    localparam int T_AP_AC_US = 1000000;
    localparam int T_RANGE_US = 200;
    localparam int CYC_FN_DC_RES = T_FN_DC_RES_US * CLK_MHZ;
    localparam int CYC_FN_FROM_AC = T_FN_FROM_AC_US * CLK_MHZ;
    localparam int CYC_FN_TO_AC_AZ = T_FN_TO_AC_AZ_US * CLK_MHZ;
    localparam int CYC_FN_TO_AC = T_FN_TO_AC_US * CLK_MHZ;
    localparam int CYC_AP_123 = T_AP_123_US * CLK_MHZ;
    localparam int CYC_AP_106 = T_AP_106_US * CLK_MHZ;
    localparam int CYC_AP_36 = T_AP_36_US * CLK_MHZ;
    localparam int CYC_AP_24 = T_AP_24_US * CLK_MHZ;
    localparam int CYC_AP_23 = T_AP_23_US * CLK_MHZ;
    localparam int CYC_AP_AC = T_AP_AC_US * CLK_MHZ;
    localparam int CYC_RANGE = T_RANGE_US * CLK_MHZ;
    // Command states
    typedef enum logic [2:0] {
        CS_IDLE = 3'b001,
        CS_PARAM = 3'b010,
        CS_EXEC = 3'b100
    } mdi_cmd_state_t;
endpackage

/* logic/mdi_busy_timer.sv */
// Busy countdown that holds off measurements during a change
`timescale 1ns/1ns
module mdi_busy_timer #(
    parameter int CNT_W = 28
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Load
    input wire logic load,
    input wire logic [CNT_W-1:0] loadCycles,
    // State
    output logic busy
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;

    initial begin
        if (CNT_W < 27) $error("mdi_busy_timer: CNT_W too small");
    end

    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = loadCycles; // R20
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - CNT_W'(1);
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != '0);
endmodule // mdi_busy_timer

/* logic/mdi_irq_gate.sv */
// Interrupt request gating from live conditions and the enable mask
`timescale 1ns/1ns
module mdi_irq_gate #(
    parameter int MASK_W = mdi_pkg::MASK_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Conditions and mask
    input wire logic [MASK_W-1:0] cond,
    input wire logic [MASK_W-1:0] mask,
    // Request
    output logic irqReq
);
    logic irq_q;
    logic irq_d;

    initial begin
        if (MASK_W != 5) $error("mdi_irq_gate: MASK_W must be 5");
    end

    always_comb begin
        irq_d = |(cond & mask); // R19
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irqReq = irq_q;
endmodule // mdi_irq_gate

/* testbench/mdi_host_model.sv */
// Controller model that drives the register port from the host side
`timescale 1ns/1ns
module mdi_host_model (
    // Clock
    input wire logic core_clk,
    // Register port
    output logic [3:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrite,
    output logic regRead,
    input wire logic [7:0] regRdData
);
    initial begin
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // Idle bus shows inverted values, so stale data never looks valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        regAddr <= ~a;
        #1 d = regRdData;
    endtask
    // Opcode then parameter, then one idle cycle
    task automatic cmd(input logic [7:0] op, input logic [7:0] p);
        wr(mdi_pkg::OFS_CMD, op);
        wr(mdi_pkg::OFS_PARAM, p);
        @(posedge core_clk);
        // Settle past the update edge before anyone looks at outputs
        #1;
    endtask
    task automatic cmd0(input logic [7:0] op);
        wr(mdi_pkg::OFS_CMD, op);
        @(posedge core_clk);
    endtask
endmodule // mdi_host_model

/* testbench/tb_top.sv */
// Self-checking bench for the meter command interpreter
`timescale 1ns/1ns
module tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic readingAvail = 1'b0;
    logic measComplete = 1'b0;
    logic bufHalfFull = 1'b0;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData, funcOut, rangeOut, apertureOut, d;
    logic regWrite, regRead, irqOut, busyOut;
    logic [23:0] trigDelayOut;
    int err_count = 0;
    int samples_checked = 0;
    int seed = 32'h2c4e;
    int n;
    logic [7:0] m;
    always #5 core_clk = ~core_clk;
    mdi_host_model i_host (.core_clk(core_clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData));
    mdi_meter_ctrl i_dut (.core_clk(core_clk), .reset(reset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData(regRdData),
        .readingAvail(readingAvail), .measComplete(measComplete),
        .bufHalfFull(bufHalfFull), .irqOut(irqOut), .busyOut(busyOut),
        .funcOut(funcOut), .rangeOut(rangeOut),
        .apertureOut(apertureOut), .trigDelayOut(trigDelayOut));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [23:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        chk("func", funcOut, mdi_pkg::RST_FUNC);
        chk("range", rangeOut, mdi_pkg::RST_RANGE);
        chk("aper", apertureOut, mdi_pkg::RST_APER);
        chk("busy", busyOut, 1'b0);
        chk("irq", irqOut, 1'b0);
    endtask
    // Bounded wait for busy to reach a level; returns cycles spent
    task automatic wait_busy(input logic lvl, input int lim);
        n = 0;
        while (busyOut !== lvl) begin
            @(posedge core_clk);
            #1 n++;
            if (n > lim) begin
                chk("busy wait", 1'b1, 1'b0);
                final_report();
            end
        end
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge core_clk);
        #1 chk("irq", irqOut, e);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        // Single weights first, then random masks
        for (int i = 0; i < 12; i++) begin
            m = (i < 5) ? 8'(1 << i) : 8'($random(seed) & 32'h1F);
            i_host.cmd(mdi_pkg::OP_IRQ_EN, m);
            i_host.cmd0(mdi_pkg::OP_IRQ_QRY);
            i_host.rd(mdi_pkg::OFS_RESP, d);
            chk("mask", d, m);
        end
        i_host.cmd(mdi_pkg::OP_IRQ_EN, 8'h10);
        @(posedge core_clk) bufHalfFull <= 1'b1;
        irq_is(1'b1);
        i_host.cmd(mdi_pkg::OP_IRQ_EN, 8'h00);
        irq_is(1'b0);
        @(posedge core_clk) bufHalfFull <= 1'b0;
        i_host.cmd(mdi_pkg::OP_IRQ_EN, 8'h08);
        irq_is(1'b0);
        @(posedge core_clk) measComplete <= 1'b1;
        @(posedge core_clk) measComplete <= 1'b0;
        irq_is(1'b1);
        do_reset();
        i_host.cmd(mdi_pkg::OP_IRQ_EN, 8'h01);
        @(posedge core_clk) readingAvail <= 1'b1;
        @(posedge core_clk) readingAvail <= 1'b0;
        irq_is(1'b1);
        // Unknown opcode raises the error condition
        i_host.cmd(mdi_pkg::OP_IRQ_EN, 8'h04);
        irq_is(1'b0);
        i_host.cmd0(8'h7E);
        irq_is(1'b1);
        i_host.rd(mdi_pkg::OFS_STATUS, d);
        chk("noerr", d[mdi_pkg::ST_NOERR], 1'b0);
        i_host.cmd0(mdi_pkg::OP_SEND_ERR);
        i_host.rd(mdi_pkg::OFS_RESP, d);
        chk("errcode", d, mdi_pkg::ERR_BAD_OP);
        irq_is(1'b0);
        // Range change: busy length, then done flag interrupt
        i_host.cmd(mdi_pkg::OP_IRQ_EN, 8'h02);
        i_host.cmd(mdi_pkg::OP_RANGE, 8'h01);
        chk("range", rangeOut, 8'h01);
        wait_busy(1'b1, 10);
        wait_busy(1'b0, mdi_pkg::CYC_RANGE + 10);
        chk("busylen", n >= mdi_pkg::CYC_RANGE - 1, 1'b1);
        chk("busymax", n <= mdi_pkg::CYC_RANGE + 3, 1'b1);
        irq_is(1'b1);
        i_host.cmd(mdi_pkg::OP_APER, mdi_pkg::AP_10US);
        chk("aper", apertureOut, mdi_pkg::AP_10US);
        chk("busy", busyOut, 1'b1);
        // Function changes start busy; AC voltage loads trigger delay
        do_reset();
        i_host.cmd(mdi_pkg::OP_FUNC, mdi_pkg::FN_RES);
        chk("func", funcOut, mdi_pkg::FN_RES);
        wait_busy(1'b1, 10);
        do_reset();
        i_host.cmd(mdi_pkg::OP_FUNC, mdi_pkg::FN_ACV);
        chk("func", funcOut, mdi_pkg::FN_ACV);
        chk("tdly", trigDelayOut, mdi_pkg::ACV_TDELAY);
        wait_busy(1'b1, 10);
        i_host.wr(mdi_pkg::OFS_CMD, mdi_pkg::OP_TDELAY);
        i_host.wr(mdi_pkg::OFS_PARAM, 8'h12);
        i_host.wr(mdi_pkg::OFS_PARAM, 8'h34);
        i_host.wr(mdi_pkg::OFS_PARAM, 8'h56);
        repeat (3) @(posedge core_clk);
        #1 chk("tdly", trigDelayOut, 24'h123456);
        i_host.cmd(mdi_pkg::OP_APER, mdi_pkg::AP_2MS5);
        chk("aper", apertureOut, mdi_pkg::AP_2MS5);
        i_host.cmd0(mdi_pkg::OP_STAT_QRY);
        i_host.rd(mdi_pkg::OFS_RESP, d);
        chk("stat", d, mdi_pkg::FN_ACV);
        do_reset();
        final_report();
    end
endmodule // tb_top
